// *** alert_flag.sv ***
`timescale 1ns/100ps
module alert_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clear,
  input wire logic clear_allow,
  output logic flag
);

  logic next_flag;

  // ------------------------------------------------------------
  // sticky flag, set wins over clear
  // ------------------------------------------------------------
  always_comb
  begin
    next_flag = flag;
    if (clear && clear_allow)
    begin
      next_flag = 1'b0;
    end
    if (set)
    begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
    end
  end

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
    set |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag not set after set request");

endmodule

// *** balance_alert_pkg.sv ***
package balance_alert_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_SUMMARY = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_RUN_STATUS = 8'h1C;

  // ------------------------------------------------------------
  // summary flag layout, bits 15..11
  // ------------------------------------------------------------
  localparam int FLAG_LSB = 11;
  localparam int FLAG_COUNT = 5;
  localparam int IDX_TIMEOUT = 4;
  localparam int IDX_THERMAL = 3;
  localparam int IDX_CALIB = 2;
  localparam int IDX_NOTICE = 1;
  localparam int IDX_COMPLETE = 0;

  // ------------------------------------------------------------
  // config and run status layout
  // ------------------------------------------------------------
  localparam int CFG_WDOG_DIS_BIT = 0;
  localparam int CFG_THERM_EN_BIT = 1;
  localparam int CFG_NOTICE_LSB = 4;
  localparam int NOTICE_W = 4;
  localparam int RUN_ACTIVE_BIT = 0;
  localparam int RUN_MODE_LSB = 1;
  localparam int RUN_COUNT_LSB = 4;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [4:0] FLAG_RESET = 5'h0;
  localparam logic [4:0] MASK_RESET = 5'h0;
  localparam logic CFG_WDOG_DIS_RESET = 1'b0;
  localparam logic CFG_THERM_EN_RESET = 1'b0;
  localparam logic [3:0] NOTICE_RESET = 4'h0;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_DISCHARGE = 2'b01,
    MODE_AUTOMATED = 2'b10,
    MODE_RESERVED = 2'b11
  } run_mode_e;

endpackage

// *** balancing_alert_status.sv ***
// Behaviour
// - watchdog halt sets timeout flag bit 15
// - timeout flag only when watchdog disable zero
// - thermal halt sets thermal flag bit 14
// - thermal flag only when thermal check enabled
// - thermal, calibration clear only after run ends
// - calibration fault halt sets bit 13
// - periodic progress notice sets bit 12
// - notice config governs enable and period
// - normal timer or undervoltage exit sets bit 11
// - write zero clears, write one ignored
// - flags zero until their event occurs
// - summary register readable and writable
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
module balancing_alert_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  output logic irq,
  input wire logic run_active,
  input wire balance_alert_pkg::run_mode_e run_mode,
  input wire logic halt_watchdog,
  input wire logic halt_thermal,
  input wire logic halt_calibration,
  input wire logic progress_tick,
  input wire logic exit_timer,
  input wire logic exit_undervoltage
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // discharge and automated runs only
  function automatic logic tracked_mode(input balance_alert_pkg::run_mode_e m);
    tracked_mode = (m == balance_alert_pkg::MODE_DISCHARGE) ||
      (m == balance_alert_pkg::MODE_AUTOMATED);
  endfunction

  // ------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------
  logic balance_watchdog_disable;
  logic balance_thermal_check_enable;
  logic [3:0] balance_notice_config;
  logic next_balance_watchdog_disable;
  logic next_balance_thermal_check_enable;
  logic [3:0] next_balance_notice_config;

  always_comb
  begin
    next_balance_watchdog_disable = balance_watchdog_disable;
    next_balance_thermal_check_enable = balance_thermal_check_enable;
    next_balance_notice_config = balance_notice_config;
    if (wr_en && hit(addr, balance_alert_pkg::OFF_CONFIG))
    begin
      next_balance_watchdog_disable = wdata[balance_alert_pkg::CFG_WDOG_DIS_BIT];
      next_balance_thermal_check_enable = wdata[balance_alert_pkg::CFG_THERM_EN_BIT];
      next_balance_notice_config =
        wdata[balance_alert_pkg::CFG_NOTICE_LSB +: balance_alert_pkg::NOTICE_W];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      balance_watchdog_disable <= balance_alert_pkg::CFG_WDOG_DIS_RESET;
      balance_thermal_check_enable <= balance_alert_pkg::CFG_THERM_EN_RESET;
      balance_notice_config <= balance_alert_pkg::NOTICE_RESET;
    end
    else
    begin
      balance_watchdog_disable <= next_balance_watchdog_disable;
      balance_thermal_check_enable <= next_balance_thermal_check_enable;
      balance_notice_config <= next_balance_notice_config;
    end
  end

  // ------------------------------------------------------------
  // event qualification
  // ------------------------------------------------------------
  logic [4:0] flag_set;
  logic notice_set;

  always_comb
  begin
    flag_set = 5'h0;
    flag_set[balance_alert_pkg::IDX_TIMEOUT] = halt_watchdog && run_active &&
      tracked_mode(run_mode) && !balance_watchdog_disable;
    flag_set[balance_alert_pkg::IDX_THERMAL] = halt_thermal && run_active &&
      balance_thermal_check_enable;
    flag_set[balance_alert_pkg::IDX_CALIB] = halt_calibration && run_active &&
      tracked_mode(run_mode);
    flag_set[balance_alert_pkg::IDX_NOTICE] = notice_set;
    flag_set[balance_alert_pkg::IDX_COMPLETE] = (exit_timer || exit_undervoltage) &&
      run_active;
  end

  // ------------------------------------------------------------
  // progress notice period counter
  // ------------------------------------------------------------
  logic [3:0] notice_count;
  logic [3:0] next_notice_count;
  logic notice_tick;

  assign notice_tick = progress_tick && run_active && tracked_mode(run_mode) &&
    (balance_notice_config != 4'h0);
  always_comb
  begin
    next_notice_count = notice_count;
    notice_set = 1'b0;
    if (!run_active)
    begin
      next_notice_count = 4'h0;
    end
    else if (notice_tick)
    begin
      next_notice_count = 4'(notice_count + 4'h1);
      if (next_notice_count >= balance_notice_config)
      begin
        next_notice_count = 4'h0;
        notice_set = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      notice_count <= 4'h0;
    end
    else
    begin
      notice_count <= next_notice_count;
    end
  end

  // ------------------------------------------------------------
  // summary flags
  // ------------------------------------------------------------
  logic [4:0] flags;
  logic [4:0] flag_clear;
  logic [4:0] clear_allow;
  logic summary_wr;

  assign summary_wr = wr_en && hit(addr, balance_alert_pkg::OFF_SUMMARY);
  always_comb
  begin
    flag_clear = {5{summary_wr}} &
      ~wdata[balance_alert_pkg::FLAG_LSB +: balance_alert_pkg::FLAG_COUNT];
    clear_allow = 5'h1F;
    clear_allow[balance_alert_pkg::IDX_THERMAL] = !run_active;
    clear_allow[balance_alert_pkg::IDX_CALIB] = !run_active;
  end

  for (genvar i = 0; i < balance_alert_pkg::FLAG_COUNT; i++)
  begin : g_flag
    alert_flag u_flag (
      .clk(clk),
      .rst_n(rst_n),
      .set(flag_set[i]),
      .clear(flag_clear[i]),
      .clear_allow(clear_allow[i]),
      .flag(flags[i])
    );
  end

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  logic [4:0] irq_status;
  logic [4:0] irq_mask;
  logic [4:0] next_irq_status;
  logic [4:0] next_irq_mask;

  always_comb
  begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (rd_en && hit(addr, balance_alert_pkg::OFF_IRQ_STATUS))
    begin
      next_irq_status = 5'h0;
    end
    next_irq_status = next_irq_status | flag_set;
    if (wr_en && hit(addr, balance_alert_pkg::OFF_IRQ_MASK))
    begin
      next_irq_mask = wdata[balance_alert_pkg::FLAG_LSB +: balance_alert_pkg::FLAG_COUNT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_status <= balance_alert_pkg::FLAG_RESET;
      irq_mask <= balance_alert_pkg::MASK_RESET;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    if (rd_en)
    begin
      case (addr)
        balance_alert_pkg::OFF_SUMMARY:
          next_rdata[balance_alert_pkg::FLAG_LSB +: balance_alert_pkg::FLAG_COUNT] =
            flags;
        balance_alert_pkg::OFF_CONFIG:
        begin
          next_rdata[balance_alert_pkg::CFG_WDOG_DIS_BIT] = balance_watchdog_disable;
          next_rdata[balance_alert_pkg::CFG_THERM_EN_BIT] = balance_thermal_check_enable;
          next_rdata[balance_alert_pkg::CFG_NOTICE_LSB +: balance_alert_pkg::NOTICE_W] =
            balance_notice_config;
        end
        balance_alert_pkg::OFF_IRQ_STATUS:
          next_rdata[balance_alert_pkg::FLAG_LSB +: balance_alert_pkg::FLAG_COUNT] =
            irq_status;
        balance_alert_pkg::OFF_IRQ_MASK:
          next_rdata[balance_alert_pkg::FLAG_LSB +: balance_alert_pkg::FLAG_COUNT] =
            irq_mask;
        balance_alert_pkg::OFF_RUN_STATUS:
        begin
          next_rdata[balance_alert_pkg::RUN_ACTIVE_BIT] = run_active;
          next_rdata[balance_alert_pkg::RUN_MODE_LSB +: 2] = run_mode;
          next_rdata[balance_alert_pkg::RUN_COUNT_LSB +: balance_alert_pkg::NOTICE_W] =
            notice_count;
        end
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata <= balance_alert_pkg::RDATA_RESET;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_timeout_set;
    (halt_watchdog && run_active && tracked_mode(run_mode) && !balance_watchdog_disable)
      |=> flags[balance_alert_pkg::IDX_TIMEOUT];
  endproperty
  a_timeout_set: assert property (p_timeout_set)
    else $error("timeout flag missed a watchdog halt");
  property p_timeout_disabled;
    $rose(flags[balance_alert_pkg::IDX_TIMEOUT]) |-> !$past(balance_watchdog_disable);
  endproperty
  a_timeout_disabled: assert property (p_timeout_disabled)
    else $error("timeout flag rose while watchdog alert disabled");
  property p_thermal_set;
    (halt_thermal && run_active && balance_thermal_check_enable)
      |=> flags[balance_alert_pkg::IDX_THERMAL];
  endproperty
  a_thermal_set: assert property (p_thermal_set)
    else $error("thermal flag missed a thermal halt");
  property p_thermal_enable;
    $rose(flags[balance_alert_pkg::IDX_THERMAL]) |-> $past(balance_thermal_check_enable);
  endproperty
  a_thermal_enable: assert property (p_thermal_enable)
    else $error("thermal flag rose with thermal check off");
  property p_halt_clear_after_run;
    ($fell(flags[balance_alert_pkg::IDX_THERMAL]) || $fell(flags[balance_alert_pkg::IDX_CALIB]))
      |-> $past(!run_active && summary_wr);
  endproperty
  a_halt_clear_after_run: assert property (p_halt_clear_after_run)
    else $error("halt flag cleared while run active");
  property p_calib_set;
    (halt_calibration && run_active && tracked_mode(run_mode))
      |=> flags[balance_alert_pkg::IDX_CALIB];
  endproperty
  a_calib_set: assert property (p_calib_set)
    else $error("calibration flag missed a calibration halt");
  property p_notice_cause;
    $rose(flags[balance_alert_pkg::IDX_NOTICE])
      |-> $past(progress_tick && run_active && balance_notice_config != 4'h0);
  endproperty
  a_notice_cause: assert property (p_notice_cause)
    else $error("notice flag rose without an enabled progress tick");
  property p_notice_period_one;
    (notice_tick && balance_notice_config == 4'h1)
      |=> flags[balance_alert_pkg::IDX_NOTICE] && notice_count == 4'h0;
  endproperty
  a_notice_period_one: assert property (p_notice_period_one)
    else $error("notice period of one tick not honoured");
  property p_complete_set;
    ((exit_timer || exit_undervoltage) && run_active) |=> flags[balance_alert_pkg::IDX_COMPLETE];
  endproperty
  a_complete_set: assert property (p_complete_set)
    else $error("completion flag missed a normal exit");
  property p_clear_by_write;
    (flags != 5'h0 && !summary_wr) |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_clear_by_write: assert property (p_clear_by_write)
    else $error("flag dropped without a write of zero");
  property p_rise_needs_run;
    $rose(flags[balance_alert_pkg::IDX_COMPLETE]) |-> $past(run_active);
  endproperty
  a_rise_needs_run: assert property (p_rise_needs_run)
    else $error("completion flag rose with no run");
  property p_summary_read;
    (rd_en && hit(addr, balance_alert_pkg::OFF_SUMMARY))
      |=> rdata == {$past(flags), 11'h000};
  endproperty
  a_summary_read: assert property (p_summary_read)
    else $error("summary read data wrong");
endmodule

// *** balancing_alert_status_test.sv ***
`timescale 1ns/100ps
module balancing_alert_status_test;
  logic clk;
  logic rst_n;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [15:0] rdata;
  logic irq;
  logic run_active;
  balance_alert_pkg::run_mode_e run_mode;
  // watchdog, thermal, calibration, tick, timer, undervoltage
  logic [5:0] ev;
  int n_errors;
  int tests_run;

  balancing_alert_status balancing_alert_status_i (
    .clk(clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .irq(irq),
    .run_active(run_active),
    .run_mode(run_mode),
    .halt_watchdog(ev[0]),
    .halt_thermal(ev[1]),
    .halt_calibration(ev[2]),
    .progress_tick(ev[3]),
    .exit_timer(ev[4]),
    .exit_undervoltage(ev[5])
  );

  // ------------------------------------------------------------
  // clock and helpers
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string name);
    logic [15:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask

  task automatic sum_chk(input logic [15:0] exp);
    rd_chk(balance_alert_pkg::OFF_SUMMARY, exp, "summary");
  endtask

  task automatic cfg(input logic [3:0] n, input logic therm, input logic wdis);
    wr(balance_alert_pkg::OFF_CONFIG, {8'h00, n, 2'b00, therm, wdis});
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
    #1;
  endtask

  task automatic run(input logic on, input balance_alert_pkg::run_mode_e m);
    @(posedge clk);
    run_active <= on;
    run_mode <= m;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    sum_chk(16'h0000);
    rd_chk(balance_alert_pkg::OFF_CONFIG, 16'h0000, "config");
    check("irq", {15'h0000, irq}, 16'h0000);
  endtask

  task automatic t_timeout();
    cfg(4'h0, 1'b0, 1'b0);
    run(1'b1, balance_alert_pkg::MODE_DISCHARGE);
    sum_chk(16'h0000);
    pulse(0);
    sum_chk(16'h8000);
    run(1'b0, balance_alert_pkg::MODE_DISCHARGE);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    sum_chk(16'h0000);
    run(1'b1, balance_alert_pkg::MODE_MANUAL);
    pulse(0);
    sum_chk(16'h0000);
    cfg(4'h0, 1'b0, 1'b1);
    run(1'b1, balance_alert_pkg::MODE_AUTOMATED);
    pulse(0);
    sum_chk(16'h0000);
    run(1'b0, balance_alert_pkg::MODE_MANUAL);
  endtask

  task automatic t_thermal();
    cfg(4'h0, 1'b0, 1'b0);
    run(1'b1, balance_alert_pkg::MODE_MANUAL);
    pulse(1);
    sum_chk(16'h0000);
    cfg(4'h0, 1'b1, 1'b0);
    pulse(1);
    sum_chk(16'h4000);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    sum_chk(16'h4000);
    run(1'b0, balance_alert_pkg::MODE_MANUAL);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    sum_chk(16'h0000);
  endtask

  task automatic t_calib();
    cfg(4'h0, 1'b0, 1'b0);
    run(1'b1, balance_alert_pkg::MODE_MANUAL);
    pulse(2);
    sum_chk(16'h0000);
    run(1'b1, balance_alert_pkg::MODE_AUTOMATED);
    pulse(2);
    pulse(4);
    sum_chk(16'h2800);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'hFFFF);
    sum_chk(16'h2800);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    sum_chk(16'h2000);
    run(1'b0, balance_alert_pkg::MODE_MANUAL);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    sum_chk(16'h0000);
  endtask

  task automatic t_notice();
    cfg(4'h3, 1'b0, 1'b0);
    run(1'b1, balance_alert_pkg::MODE_DISCHARGE);
    pulse(3);
    pulse(3);
    sum_chk(16'h0000);
    pulse(3);
    sum_chk(16'h1000);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    cfg(4'h0, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++)
      pulse(3);
    sum_chk(16'h0000);
    cfg(4'h1, 1'b0, 1'b0);
    pulse(3);
    sum_chk(16'h1000);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    run(1'b0, balance_alert_pkg::MODE_MANUAL);
  endtask

  task automatic t_done();
    run(1'b1, balance_alert_pkg::MODE_MANUAL);
    pulse(5);
    run(1'b0, balance_alert_pkg::MODE_MANUAL);
    sum_chk(16'h0800);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
    pulse(4);
    sum_chk(16'h0000);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h07FF);
    sum_chk(16'h0000);
    rd_chk(8'h20, 16'h0000, "unmapped");
    run(1'b1, balance_alert_pkg::MODE_AUTOMATED);
    rd_chk(balance_alert_pkg::OFF_RUN_STATUS, 16'h0005, "run_status");
    run(1'b0, balance_alert_pkg::MODE_MANUAL);
  endtask

  task automatic t_irq();
    rd_chk(balance_alert_pkg::OFF_IRQ_STATUS, 16'hF800, "irq_status");
    rd_chk(balance_alert_pkg::OFF_IRQ_STATUS, 16'h0000, "irq_status");
    wr(balance_alert_pkg::OFF_IRQ_MASK, 16'hF800);
    run(1'b1, balance_alert_pkg::MODE_MANUAL);
    pulse(4);
    check("irq", {15'h0000, irq}, 16'h0001);
    rd_chk(balance_alert_pkg::OFF_IRQ_STATUS, 16'h0800, "irq_status");
    check("irq", {15'h0000, irq}, 16'h0000);
    sum_chk(16'h0800);
    wr(balance_alert_pkg::OFF_IRQ_MASK, 16'h0000);
    pulse(5);
    check("irq", {15'h0000, irq}, 16'h0000);
    rd_chk(balance_alert_pkg::OFF_IRQ_STATUS, 16'h0800, "irq_status");
    run(1'b0, balance_alert_pkg::MODE_MANUAL);
    wr(balance_alert_pkg::OFF_SUMMARY, 16'h0000);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    run_active = 1'b0;
    run_mode = balance_alert_pkg::MODE_MANUAL;
    ev = 6'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_timeout();
    t_thermal();
    t_calib();
    t_notice();
    t_done();
    t_irq();
    end_of_test();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule
